// ===== rtl/bcd_accumulator_alu.sv
// What this block does
// - 16-bit BCD sum of memory word into accumulator
// - 32-bit BCD sum, two words or immediate
// - Carry flags for 16- and 32-bit sums
// - 16-bit BCD difference from accumulator low half
// - 32-bit BCD difference, two words or immediate
// - Borrow flags for 16- and 32-bit differences
// - BCD product of low half, eight-digit result
// - BCD quotient to accumulator, remainder to stack
// - Division raises range flag on unusable operand
// - Zero flag after arithmetic, increment, decrement
// - Negative flag from accumulator top bit
// - Non-BCD operand raises non-BCD flag
// - Flags hold until an affecting instruction
// - Increment adds one to memory word
// - Decrement subtracts one from memory word
// - Left shift 1 to 32, zero fill
// - Right shift 1 to 32, zero fill
// - Encoder gives index of set bit
// - Encoder gives zero for input zero or one
// - Several bits: lowest index, range flag
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module bcd_accumulator_alu
  import alu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  output logic done,
  output logic mem_wr_valid,
  output logic [WORD_W-1:0] mem_wr_data,
  output logic [ACC_W-1:0] acc,
  output logic [ACC_W-1:0] stack1,
  output flags_t flags,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [ACC_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ACC_W-1:0] reg_rdata
);

  function automatic logic is_bcd(input logic [ACC_W-1:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < DIGITS; i++) begin
      if (v[4*i+:4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Returns carry out above the top digit and the digit sum
  function automatic logic [ACC_W:0] bcd_add(input logic [ACC_W-1:0] a,
                                             input logic [ACC_W-1:0] b);
    logic [4:0] s;
    logic c;
    logic [ACC_W-1:0] r;
    c = 1'b0;
    r = '0;
    for (int i = 0; i < DIGITS; i++) begin
      s = {1'b0, a[4*i+:4]} + {1'b0, b[4*i+:4]} + {4'h0, c};
      if (s > 5'h09) begin
        s = s + 5'h06;
      end
      c = s[4];
      r[4*i+:4] = s[3:0];
    end
    return {c, r};
  endfunction

  // Returns borrow out of the top digit and the ten's complement difference
  function automatic logic [ACC_W:0] bcd_sub(input logic [ACC_W-1:0] a,
                                             input logic [ACC_W-1:0] b);
    logic [4:0] s;
    logic c;
    logic [ACC_W-1:0] r;
    c = 1'b0;
    r = '0;
    for (int i = 0; i < DIGITS; i++) begin
      s = {1'b0, a[4*i+:4]} - {1'b0, b[4*i+:4]} - {4'h0, c};
      c = s[4];
      if (c) begin
        s = s + 5'h0a;
      end
      r[4*i+:4] = s[3:0];
    end
    return {c, r};
  endfunction

  function automatic logic [BIN_W-1:0] bcd_to_bin(input logic [ACC_W-1:0] a);
    logic [BIN_W-1:0] v;
    v = '0;
    for (int i = DIGITS - 1; i >= 0; i--) begin
      v = BIN_W'(v * 27'h000000a) + {23'h000000, a[4*i+:4]};
    end
    return v;
  endfunction

  function automatic logic [ACC_W-1:0] bin_to_bcd(input logic [BIN_W-1:0] v);
    logic [ACC_W-1:0] d;
    d = '0;
    for (int i = BIN_W - 1; i >= 0; i--) begin
      for (int j = 0; j < DIGITS; j++) begin
        if (d[4*j+:4] > 4'h4) begin
          d[4*j+:4] = d[4*j+:4] + 4'h3;
        end
      end
      d = {d[ACC_W-2:0], v[i]};
    end
    return d;
  endfunction

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic [ACC_W-1:0] stack1_q;
  logic [ACC_W-1:0] stack1_d;
  flags_t flags_q;
  flags_t flags_d;
  logic acc_we;
  logic stack_we;
  logic mem_we;
  logic [WORD_W-1:0] mem_d;
  logic mem_wr_valid_q;
  logic [WORD_W-1:0] mem_wr_data_q;
  logic done_q;
  logic [ACC_W-1:0] reg_rdata_q;

  logic [ACC_W-1:0] opnd32;
  logic [ACC_W-1:0] opnd16;
  logic [ACC_W-1:0] acc_lo;
  logic [ACC_W:0] sum16;
  logic [ACC_W:0] sum32;
  logic [ACC_W:0] dif16;
  logic [ACC_W:0] dif32;
  logic [BIN_W-1:0] bin_acc;
  logic [BIN_W-1:0] bin_acc_lo;
  logic [BIN_W-1:0] bin_opnd;
  logic [BIN_W-1:0] product;
  logic [BIN_W-1:0] quotient;
  logic [BIN_W-1:0] remainder;
  logic [WORD_W-1:0] bump_up;
  logic [WORD_W-1:0] bump_down;
  logic [SHIFT_W-1:0] shift_cnt;
  logic [4:0] low_index;
  logic many_bits;

  // Double-width memory operand arrives as both words in the same cycle, high word above low word
  assign opnd32 = cmd.imm_sel ? cmd.imm : {cmd.mem_hi, cmd.mem_lo};
  assign opnd16 = cmd.imm_sel ? {16'h0000, cmd.imm[15:0]} : {16'h0000, cmd.mem_lo};
  assign acc_lo = {16'h0000, acc_q[15:0]};

  assign sum16 = bcd_add(acc_lo, opnd16);
  assign sum32 = bcd_add(acc_q, opnd32);
  assign dif16 = bcd_sub(acc_lo, opnd16);
  assign dif32 = bcd_sub(acc_q, opnd32);

  // Binary detour keeps multiply and divide in one cycle at 25 MHz
  assign bin_acc = bcd_to_bin(acc_q);
  assign bin_acc_lo = bcd_to_bin(acc_lo);
  assign bin_opnd = bcd_to_bin(opnd16);
  assign product = BIN_W'(bin_acc_lo * bin_opnd);
  assign quotient = (bin_opnd == '0) ? '0 : bin_acc / bin_opnd;
  assign remainder = (bin_opnd == '0) ? '0 : bin_acc % bin_opnd;

  assign bump_up = cmd.mem_lo + 16'h0001;
  assign bump_down = cmd.mem_lo - 16'h0001;
  assign shift_cnt = opnd32[SHIFT_W-1:0];

  always_comb begin
    low_index = 5'h00;
    for (int i = ACC_W - 1; i >= 0; i--) begin
      if (acc_q[i]) begin
        low_index = 5'(i);
      end
    end
  end

  assign many_bits = (acc_q & (acc_q - 32'h0000_0001)) != 32'h0000_0000;

  always_comb begin
    acc_d = acc_q;
    stack1_d = stack1_q;
    flags_d = flags_q;
    acc_we = 1'b0;
    stack_we = 1'b0;
    mem_we = 1'b0;
    mem_d = 16'h0000;
    unique case (cmd.op)
      OP_BCD_SUM_16: begin
        acc_we = 1'b1;
        acc_d = {16'h0000, sum16[15:0]};
        flags_d.carry16_flag = sum16[16];
        flags_d.non_bcd_flag = !(is_bcd(acc_lo) && is_bcd(opnd16));
        flags_d.result_zero_flag = (sum16[15:0] == 16'h0000);
        flags_d.negative_flag = 1'b0;
      end
      OP_BCD_SUM_32: begin
        acc_we = 1'b1;
        acc_d = sum32[ACC_W-1:0];
        flags_d.carry32_flag = sum32[ACC_W];
        flags_d.non_bcd_flag = !(is_bcd(acc_q) && is_bcd(opnd32));
        flags_d.result_zero_flag = (sum32[ACC_W-1:0] == 32'h0000_0000);
        flags_d.negative_flag = sum32[ACC_W-1];
      end
      OP_BCD_MINUS_16: begin
        acc_we = 1'b1;
        acc_d = {16'h0000, dif16[15:0]};
        flags_d.borrow16_flag = dif16[ACC_W];
        flags_d.non_bcd_flag = !(is_bcd(acc_lo) && is_bcd(opnd16));
        flags_d.result_zero_flag = (dif16[15:0] == 16'h0000);
        flags_d.negative_flag = 1'b0;
      end
      OP_BCD_MINUS_32: begin
        acc_we = 1'b1;
        acc_d = dif32[ACC_W-1:0];
        flags_d.borrow32_flag = dif32[ACC_W];
        flags_d.non_bcd_flag = !(is_bcd(acc_q) && is_bcd(opnd32));
        flags_d.result_zero_flag = (dif32[ACC_W-1:0] == 32'h0000_0000);
        flags_d.negative_flag = dif32[ACC_W-1];
      end
      OP_BCD_PRODUCT_16: begin
        acc_we = 1'b1;
        acc_d = bin_to_bcd(product);
        flags_d.non_bcd_flag = !(is_bcd(acc_lo) && is_bcd(opnd16));
        flags_d.result_zero_flag = (product == '0);
        flags_d.negative_flag = acc_d[ACC_W-1];
      end
      OP_BCD_QUOTIENT_16: begin
        // A zero divisor leaves accumulator and stack untouched
        flags_d.operand_range_flag = (bin_opnd == '0);
        flags_d.non_bcd_flag = !(is_bcd(acc_q) && is_bcd(opnd16));
        if (bin_opnd != '0) begin
          acc_we = 1'b1;
          stack_we = 1'b1;
          acc_d = bin_to_bcd(quotient);
          stack1_d = bin_to_bcd(remainder);
        end
        flags_d.result_zero_flag = (acc_d == 32'h0000_0000);
        flags_d.negative_flag = acc_d[ACC_W-1];
      end
      OP_MEM_BUMP_UP: begin
        mem_we = 1'b1;
        mem_d = bump_up;
        flags_d.result_zero_flag = (bump_up == 16'h0000);
      end
      OP_MEM_BUMP_DOWN: begin
        mem_we = 1'b1;
        mem_d = bump_down;
        flags_d.result_zero_flag = (bump_down == 16'h0000);
      end
      OP_ACC_LEFT_SHIFT: begin
        // Counts of 32 and above are clipped so the result is all zeros
        acc_we = 1'b1;
        acc_d = (shift_cnt >= SHIFT_MAX) ? '0 : acc_q << shift_cnt;
      end
      OP_ACC_RIGHT_SHIFT: begin
        acc_we = 1'b1;
        acc_d = (shift_cnt >= SHIFT_MAX) ? '0 : acc_q >> shift_cnt;
      end
      OP_BIT_POSITION_TO_INDEX: begin
        acc_we = 1'b1;
        acc_d = {27'h0000000, low_index};
        if (acc_q <= 32'h0000_0001) begin
          acc_d = 32'h0000_0000;
        end
        flags_d.operand_range_flag = many_bits;
      end
      default: begin
        acc_we = 1'b0;
      end
    endcase
  end

  // An instruction that writes the accumulator wins over a bus write in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acc_q <= ACC_RESET;
    end else if (cmd_valid && acc_we) begin
      acc_q <= acc_d;
    end else if (reg_wr && reg_addr == REG_ACC) begin
      acc_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stack1_q <= STACK_RESET;
    end else if (cmd_valid && stack_we) begin
      stack1_q <= stack1_d;
    end else if (reg_wr && reg_addr == REG_STACK1) begin
      stack1_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flags_q <= FLAGS_RESET;
    end else if (cmd_valid) begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem_wr_valid_q <= 1'b0;
      mem_wr_data_q <= 16'h0000;
    end else begin
      mem_wr_valid_q <= cmd_valid && mem_we;
      if (cmd_valid && mem_we) begin
        mem_wr_data_q <= mem_d;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      done_q <= 1'b0;
    end else begin
      done_q <= cmd_valid;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata_q <= UNMAPPED_READ;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_ACC: reg_rdata_q <= acc_q;
        REG_STACK1: reg_rdata_q <= stack1_q;
        REG_FLAGS: reg_rdata_q <= {24'h000000, flags_q};
        default: reg_rdata_q <= UNMAPPED_READ;
      endcase
    end else begin
      reg_rdata_q <= UNMAPPED_READ;
    end
  end

  assign acc = acc_q;
  assign stack1 = stack1_q;
  assign flags = flags_q;
  assign done = done_q;
  assign mem_wr_valid = mem_wr_valid_q;
  assign mem_wr_data = mem_wr_data_q;
  assign reg_rdata = reg_rdata_q;

endmodule

`default_nettype wire

// ===== rtl/alu_pkg.sv
package alu_pkg;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_BCD_SUM_16 = 4'h1,
    OP_BCD_SUM_32 = 4'h3,
    OP_BCD_MINUS_16 = 4'h2,
    OP_BCD_MINUS_32 = 4'h6,
    OP_BCD_PRODUCT_16 = 4'h7,
    OP_BCD_QUOTIENT_16 = 4'h5,
    OP_MEM_BUMP_UP = 4'h4,
    OP_MEM_BUMP_DOWN = 4'hc,
    OP_ACC_LEFT_SHIFT = 4'hd,
    OP_ACC_RIGHT_SHIFT = 4'hf,
    OP_BIT_POSITION_TO_INDEX = 4'he
  } op_t;

  // One instruction as the sequencer hands it over
  typedef struct packed {
    op_t op;
    logic imm_sel;
    logic [31:0] imm;
    logic [15:0] mem_lo;
    logic [15:0] mem_hi;
  } cmd_t;

  typedef struct packed {
    logic operand_range_flag;
    logic result_zero_flag;
    logic borrow16_flag;
    logic borrow32_flag;
    logic carry16_flag;
    logic carry32_flag;
    logic negative_flag;
    logic non_bcd_flag;
  } flags_t;

  localparam int ACC_W = 32;
  localparam int WORD_W = 16;
  localparam int DIGITS = 8;
  localparam int BIN_W = 27;
  localparam int SHIFT_W = 6;
  localparam logic [SHIFT_W-1:0] SHIFT_MAX = 6'h20;

  localparam int REG_ADDR_W = 4;
  localparam logic [REG_ADDR_W-1:0] REG_ACC = 4'h0;
  localparam logic [REG_ADDR_W-1:0] REG_STACK1 = 4'h4;
  localparam logic [REG_ADDR_W-1:0] REG_FLAGS = 4'h8;

  localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;
  localparam logic [ACC_W-1:0] STACK_RESET = 32'h0000_0000;
  localparam flags_t FLAGS_RESET = 8'h00;
  localparam logic [ACC_W-1:0] UNMAPPED_READ = 32'h0000_0000;

endpackage

// ===== test/mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module mem_model (
  input wire logic clk,
  input wire logic cmd_valid,
  input wire logic [3:0] addr,
  input wire logic mem_wr_valid,
  input wire logic [15:0] mem_wr_data,
  output logic [15:0] mem_lo,
  output logic [15:0] mem_hi
);
  logic [15:0] mem [0:15];
  logic [3:0] wb_addr_q;

  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'h0000;
    end
    mem[0] = 16'h0001;
    mem[1] = 16'h0001;
    mem[2] = 16'hffff;
    mem[3] = 16'h0007;
  end

  // Outside an instruction the words are not held, so show the inverse
  assign mem_lo = cmd_valid ? mem[addr] : ~mem[addr];
  assign mem_hi = cmd_valid ? mem[addr + 4'h1] : ~mem[addr + 4'h1];

  always @(posedge clk) begin
    if (cmd_valid) begin
      wb_addr_q <= addr;
    end
    if (mem_wr_valid) begin
      mem[wb_addr_q] <= mem_wr_data;
    end
  end
endmodule

`default_nettype wire

// ===== test/alu_checker.sv
`timescale 1ns/1ps
`default_nettype none

module alu_checker
  import alu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  input wire logic done,
  input wire logic mem_wr_valid,
  input wire logic [WORD_W-1:0] mem_wr_data,
  input wire logic [ACC_W-1:0] acc,
  input wire logic [ACC_W-1:0] stack1,
  input wire flags_t flags
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence taken_s(op_t o);
    cmd_valid && cmd.op == o;
  endsequence

  sequence taken_imm_s(op_t o);
    cmd_valid && cmd.op == o && cmd.imm_sel;
  endsequence

  answer_due_a: assert property (cmd_valid |=> done)
    else $error("done missing after instruction");
  bump_up_a: assert property (taken_s(OP_MEM_BUMP_UP) |=>
    mem_wr_valid && mem_wr_data == $past(cmd.mem_lo) + 16'h0001) else $error("increment wrong");
  bump_down_a: assert property (taken_s(OP_MEM_BUMP_DOWN) |=>
    mem_wr_valid && mem_wr_data == $past(cmd.mem_lo) - 16'h0001) else $error("decrement wrong");
  bump_zero_a: assert property ((taken_s(OP_MEM_BUMP_UP) or taken_s(OP_MEM_BUMP_DOWN)) |=>
    flags.result_zero_flag == (mem_wr_data == 16'h0000)) else $error("zero flag wrong");
  flags_hold_a: assert property (!cmd_valid |=> $stable(flags))
    else $error("flags changed without instruction");
  left_shift_a: assert property (taken_imm_s(OP_ACC_LEFT_SHIFT) |=>
    acc == $past(acc) << $past(cmd.imm[5:0]) && $stable(flags)) else $error("left shift wrong");
  right_shift_a: assert property (taken_imm_s(OP_ACC_RIGHT_SHIFT) |=>
    acc == $past(acc) >> $past(cmd.imm[5:0])) else $error("right shift wrong");
  encode_range_a: assert property (taken_s(OP_BIT_POSITION_TO_INDEX) |=>
    flags.operand_range_flag == ($countones($past(acc)) > 1)) else $error("encoder range wrong");
  encode_index_a: assert property (taken_s(OP_BIT_POSITION_TO_INDEX) ##0 $onehot(acc) |=>
    acc == 32'($clog2($past(acc)))) else $error("encoder index wrong");
  encode_zero_a: assert property (taken_s(OP_BIT_POSITION_TO_INDEX) ##0
    acc < 32'h0000_0002 |=> acc == 32'h0000_0000) else $error("encoder zero case wrong");
  divide_zero_a: assert property (taken_imm_s(OP_BCD_QUOTIENT_16) ##0
    cmd.imm[15:0] == 16'h0000 |=> flags.operand_range_flag && $stable(acc) && $stable(stack1))
    else $error("divide by zero wrong");
endmodule

bind bcd_accumulator_alu alu_checker i_chk (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
  .cmd(cmd), .done(done), .mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data), .acc(acc),
  .stack1(stack1), .flags(flags));

`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
  import alu_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sel = 1'b0;
  op_t op = OP_NONE;
  logic [31:0] imm = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [3:0] addr = 4'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] mem_lo, mem_hi, mem_wr_data;
  logic done, mem_wr_valid;
  logic [31:0] acc, stack1, reg_rdata, v;
  flags_t flags;
  cmd_t cmd;
  int error_cnt = 0;
  int comparisons = 0;
  int tn = 0;
  logic [31:0] enc_in [5] = '{32'h8000_0000, 32'h0, 32'h1, 32'h0000_0110, 32'h0000_0010};
  logic [31:0] enc_out [5] = '{32'h1f, 32'h0, 32'h0, 32'h4, 32'h4};
  logic [7:0] enc_rng [5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  int counts [3] = '{1, 31, 32};

  assign cmd = '{op, sel, imm, mem_lo, mem_hi};

  bcd_accumulator_alu i_dut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd),
    .done(done), .mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data), .acc(acc),
    .stack1(stack1), .flags(flags), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  mem_model i_mem (.clk(clk), .cmd_valid(cmd_valid), .addr(addr), .mem_wr_valid(mem_wr_valid),
    .mem_wr_data(mem_wr_data), .mem_lo(mem_lo), .mem_hi(mem_hi));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Accumulator is loaded over the register port, then one instruction runs
  task automatic t(input op_t o, input logic s, input logic [31:0] i, input logic [3:0] a,
    input logic [31:0] a0, input logic [31:0] ea, input logic [7:0] m, input logic [7:0] ef);
    wr(REG_ACC, a0);
    op <= o;
    sel <= s;
    imm <= i;
    addr <= a;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk("done", 32'h1, {31'h0, done});
    chk("acc", ea, acc);
    chk("flags", {24'h0, ef}, {24'h0, flags & m});
    tn++;
    $display("test %0d ended", tn);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(REG_ACC, v);
    chk("acc reset", 32'h0, v);
    wr(REG_FLAGS, 32'hff);
    rd(REG_FLAGS, v);
    chk("flags read only", 32'h0, v);
    rd(4'hc, v);
    chk("unmapped read", 32'h0, v);
    wr(REG_STACK1, 32'h1234);
    rd(REG_STACK1, v);
    chk("stack1 rw", 32'h1234, v);
    tn++;
    $display("test %0d ended", tn);
    t(OP_BCD_SUM_16, 1'b0, 32'h0, 4'h0, 32'h9999, 32'h0, 8'h48, 8'h48);
    t(OP_BCD_SUM_32, 1'b1, 32'h1, 4'h0, 32'h9999_9999, 32'h0, 8'h44, 8'h44);
    t(OP_BCD_SUM_32, 1'b0, 32'h0, 4'h0, 32'h99, 32'h0001_0100, 8'h47, 8'h00);
    t(OP_BCD_SUM_32, 1'b1, 32'h1, 4'h0, 32'h7999_9999, 32'h8000_0000, 8'h42, 8'h02);
    t(OP_BCD_MINUS_16, 1'b0, 32'h0, 4'h3, 32'h5, 32'h9998, 8'h60, 8'h20);
    t(OP_BCD_MINUS_32, 1'b1, 32'h10, 4'h0, 32'h10, 32'h0, 8'h50, 8'h40);
    t(OP_BCD_MINUS_32, 1'b1, 32'h1, 4'h0, 32'h0, 32'h9999_9999, 8'h52, 8'h12);
    t(OP_BCD_PRODUCT_16, 1'b1, 32'h100, 4'h0, 32'h1234, 32'h0012_3400, 8'h43,
      8'h00);
    t(OP_BCD_PRODUCT_16, 1'b1, 32'h9999, 4'h0, 32'h9999, 32'h9998_0001, 8'h43,
      8'h02);
    t(OP_BCD_QUOTIENT_16, 1'b1, 32'h7, 4'h0, 32'h100, 32'h14, 8'hc1, 8'h00);
    chk("remainder", 32'h2, stack1);
    t(OP_BCD_QUOTIENT_16, 1'b1, 32'h0, 4'h0, 32'h55, 32'h55, 8'h80, 8'h80);
    t(OP_BCD_PRODUCT_16, 1'b1, 32'h0, 4'h0, 32'ha, 32'h0, 8'h41, 8'h41);
    t(OP_BCD_PRODUCT_16, 1'b1, 32'hb0, 4'h0, 32'h0, 32'h0, 8'h41, 8'h41);
    // A shift must leave the non-BCD and zero flags from the product alone
    t(OP_ACC_LEFT_SHIFT, 1'b1, 32'h4, 4'h0, 32'h8000_0001, 32'h10, 8'h41, 8'h41);
    foreach (counts[k]) begin
      t(OP_ACC_LEFT_SHIFT, 1'b1, counts[k], 4'h0, 32'h8000_0001, 32'h8000_0001 << counts[k],
        8'h00, 8'h00);
      t(OP_ACC_RIGHT_SHIFT, 1'b1, counts[k], 4'h0, 32'h8000_0001, 32'h8000_0001 >> counts[k],
        8'h00, 8'h00);
    end
    foreach (enc_in[k]) begin
      t(OP_BIT_POSITION_TO_INDEX, 1'b0, 32'h0, 4'h0, enc_in[k], enc_out[k], 8'h80,
        enc_rng[k]);
    end
    t(OP_MEM_BUMP_UP, 1'b0, 32'h0, 4'h2, 32'h1234, 32'h1234, 8'h40, 8'h40);
    chk("write back", 32'h1, {31'h0, mem_wr_valid});
    chk("up word", 32'h0, {16'h0, mem_wr_data});
    t(OP_MEM_BUMP_DOWN, 1'b0, 32'h0, 4'h2, 32'h1234, 32'h1234, 8'h40, 8'h00);
    chk("down word", 32'hffff, {16'h0, mem_wr_data});
    // Mid-run reset: every output except reg_rdata must fall back to its reset value
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk("acc after reset", 32'h0, acc);
    chk("stack1 after reset", 32'h0, stack1);
    chk("flags after reset", 32'h0, {24'h0, flags});
    chk("done after reset", 32'h0, {31'h0, done});
    chk("write back after reset", 32'h0, {31'h0, mem_wr_valid});
    chk("word after reset", 32'h0, {16'h0, mem_wr_data});
    tn++;
    $display("test %0d ended", tn);
    // An empty instruction only pulses done
    t(OP_NONE, 1'b0, 32'h0, 4'h0, 32'h4321, 32'h4321, 8'hff, 8'h00);
    t(OP_ACC_RIGHT_SHIFT, 1'b0, 32'h0, 4'h3, 32'h8000_0001, 32'h0100_0000, 8'hff,
      8'h00);
    t(OP_BCD_PRODUCT_16, 1'b0, 32'h0, 4'h3, 32'h12, 32'h84, 8'h43, 8'h00);
    report_and_stop();
  end
endmodule

`default_nettype wire
